// ---- logic/sdc_remote_dictionary_access.sv ----
// sdo client executing one remote dictionary access command at a time
// Function
// - action 0 uploads to registers, 1 downloads registers, 2 downloads constant
// - action bit 2 keeps the transfer, merges flags into existing ones
// - without accumulate, flags are replaced by this transfer's outcome
// - timeout ends command with positive set, zero and negative clear
// - read-only or missing object ends with negative only
// - success sets zero, clears positive and negative
// - timeout counts 120 us ticks
// - client 1 uses object 1280h, client 2 uses 1281h, nothing else
// - register actions start at given register, spill upward past four bytes
// - bytes packed low byte of lowest register upward
// - constant action sends a 32-bit immediate, at most four bytes
// - download low byte first; server takes only the bytes it needs
// - upload byte count caps bytes stored; later bytes are still taken from the server
// - count bit 15 lets a longer string upload end without error
// - index and sub-index address the remote entry
// - command opcode 80 (0x50), seven parameter words
// - one client talks to one server, one command in flight
// - after accumulation negative means disallowed, positive means timeout
`include "sdc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sdc_remote_dictionary_access
    import sdc_pkg::*;
#(
    parameter int NREG = 16
)
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // sdo request to remote server
    output logic             sdo_req_valid_o,
    input  wire logic        sdo_req_ready_i,
    output logic             sdo_upload_o,
    output logic      [15:0] sdo_client_obj_o,
    output logic      [15:0] sdo_index_o,
    output logic      [7:0]  sdo_subidx_o,
    output logic      [15:0] sdo_size_o,
    // download byte stream
    output logic             sdo_dl_valid_o,
    output logic      [7:0]  sdo_dl_data_o,
    input  wire logic        sdo_dl_ready_i,
    // upload byte stream
    input  wire logic        sdo_ul_valid_i,
    input  wire logic [7:0]  sdo_ul_data_i,
    output logic             sdo_ul_ready_o,
    // server completion
    input  wire logic        sdo_rsp_valid_i,
    input  wire logic [1:0]  sdo_rsp_code_i,
    // internal status word flags
    output logic             busy_o,
    output logic             isw_zero_o,
    output logic             isw_neg_o,
    output logic             isw_pos_o
);

    localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;
    localparam logic [11:0] TICK_LAST = 12'(`SDC_TICK_CYC - 1);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
        byte_of = w[8*lane +: 8];
    endfunction

    function automatic logic user_hit(input logic [7:0] a);
        user_hit = (32'(a) >= 32'(`SDC_OFF_USER)) && (32'(a) < 32'(`SDC_OFF_USER) + 32'(4 * NREG));
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == `SDC_OFF_CMD) || (a == `SDC_OFF_ACTION) || (a == `SDC_OFF_DATA)
                  || (a == `SDC_OFF_INDEX) || (a == `SDC_OFF_SUBIDX) || (a == `SDC_OFF_COUNT)
                  || (a == `SDC_OFF_TIMEOUT) || (a == `SDC_OFF_CLIENT) || (a == `SDC_OFF_STATUS)
                  || user_hit(a);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sdc_state_type state_q;
    sdc_state_type state_d;
    logic [15:0]   action_q;
    logic [31:0]   data_q;
    logic [15:0]   index_q;
    logic [7:0]    subidx_q;
    logic [15:0]   count_q;
    logic [15:0]   timeout_q;
    logic [15:0]   client_q;
    logic [31:0]   user_q [NREG];
    logic [15:0]   idx_q;
    logic [15:0]   idx_d;
    logic [11:0]   tick_div_q;
    logic [15:0]   tick_cnt_q;
    logic          acc_q;
    logic          ovf_q;
    logic          zero_q;
    logic          neg_q;
    logic          pos_q;
    logic          dl_valid_q;
    logic [7:0]    dl_byte_q;
    logic [31:0]   prdata_q;
    logic          upload_q;
    logic [15:0]   client_obj_q;
    logic [15:0]   size_q;
    logic [31:0]   rd_word;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire        idle      = (state_q == SDC_ST_IDLE);
    wire        acc_phase = psel_i & penable_i;
    wire        wr        = acc_phase & pwrite_i & reg_mapped(paddr_i);
    wire        wr_param  = wr & idle;
    wire [31:0] uoff      = 32'(paddr_i) - 32'(`SDC_OFF_USER);
    wire [IW-1:0] uidx    = uoff[IW+1:2];
    wire        wr_user   = wr & user_hit(paddr_i);
    wire        wr_cmd    = wr & (paddr_i == `SDC_OFF_CMD) & (pwdata_i == `SDC_OPCODE);

    always_comb
    begin
        if (paddr_i == `SDC_OFF_ACTION)
            rd_word = {16'h0000, action_q};
        else if (paddr_i == `SDC_OFF_DATA)
            rd_word = data_q;
        else if (paddr_i == `SDC_OFF_INDEX)
            rd_word = {16'h0000, index_q};
        else if (paddr_i == `SDC_OFF_SUBIDX)
            rd_word = {24'h00_0000, subidx_q};
        else if (paddr_i == `SDC_OFF_COUNT)
            rd_word = {16'h0000, count_q};
        else if (paddr_i == `SDC_OFF_TIMEOUT)
            rd_word = {16'h0000, timeout_q};
        else if (paddr_i == `SDC_OFF_CLIENT)
            rd_word = {16'h0000, client_q};
        else if (paddr_i == `SDC_OFF_STATUS)
            rd_word = {28'h000_0000, pos_q, neg_q, zero_q, !idle};
        else if (user_hit(paddr_i))
            rd_word = user_q[uidx];
        else
            rd_word = 32'h0000_0000;
    end

    assign pready_o  = acc_phase;
    assign pslverr_o = acc_phase & ~reg_mapped(paddr_i);
    assign prdata_o  = prdata_q;

    // read data captured in setup phase
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            prdata_q <= 32'h0000_0000;
        else if (psel_i & ~penable_i)
            prdata_q <= rd_word;
    end

    // ----------------------------------------------------------------
    // parameter words, written only while idle
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            action_q  <= 16'h0000;
            data_q    <= 32'h0000_0000;
            index_q   <= 16'h0000;
            subidx_q  <= 8'h00;
            count_q   <= 16'h0000;
            timeout_q <= 16'h0000;
            client_q  <= `SDC_CLIENT1;
        end
        else if (wr_param)
        begin
            if (paddr_i == `SDC_OFF_ACTION)  action_q  <= pwdata_i[15:0];
            if (paddr_i == `SDC_OFF_DATA)    data_q    <= pwdata_i;
            if (paddr_i == `SDC_OFF_INDEX)   index_q   <= pwdata_i[15:0];
            if (paddr_i == `SDC_OFF_SUBIDX)  subidx_q  <= pwdata_i[7:0];
            if (paddr_i == `SDC_OFF_COUNT)   count_q   <= pwdata_i[15:0];
            if (paddr_i == `SDC_OFF_TIMEOUT) timeout_q <= pwdata_i[15:0];
            if (paddr_i == `SDC_OFF_CLIENT)  client_q  <= pwdata_i[15:0];
        end
    end

    // ----------------------------------------------------------------
    // command decode and limits
    // ----------------------------------------------------------------
    wire [1:0]  act_base  = action_q[1:0];
    wire        act_ok    = (action_q[15:3] == 13'h0000) && (act_base != 2'b11);
    wire        cli_ok    = (client_q == `SDC_CLIENT1) || (client_q == `SDC_CLIENT2);
    wire        is_up     = (act_base == SDC_ACT_UPLOAD);
    wire        is_const  = (act_base == SDC_ACT_DL_CONST);
    wire [15:0] cnt15     = {1'b0, count_q[14:0]};
    wire [15:0] lim       = (is_const && cnt15 > `SDC_CONST_MAX) ? `SDC_CONST_MAX : cnt15;
    wire        start     = wr_cmd & idle & act_ok & cli_ok;
    wire        start_bad = wr_cmd & idle & ~(act_ok & cli_ok);

    // ----------------------------------------------------------------
    // byte addressing into user registers
    // ----------------------------------------------------------------
    wire [31:0] tgt       = data_q + 32'(idx_q[15:2]);
    wire        tgt_ok    = tgt < 32'(NREG);
    wire        ul_take   = (state_q == SDC_ST_XFER) & upload_q & sdo_ul_valid_i;
    wire        ul_store  = ul_take & (idx_q < lim);
    wire        ul_over   = ul_take & (idx_q >= lim) & ~count_q[`SDC_LONG_BIT];
    wire        dl_adv    = dl_valid_q & sdo_dl_ready_i;
    wire [31:0] tgt_d     = data_q + 32'(idx_d[15:2]);
    wire [31:0] src_word  = is_const ? data_q : ((tgt_d < 32'(NREG)) ? user_q[tgt_d[IW-1:0]] : 32'h0000_0000);

    assign idx_d = start ? 16'h0000 : idx_q + 16'(dl_adv | ul_store);

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_user
            wire hit_ul = ul_store & tgt_ok & (tgt[IW-1:0] == IW'(gi));
            always_ff @(posedge clock_i)
            begin
                if (!reset_n_i)
                    user_q[gi] <= 32'h0000_0000;
                else if (hit_ul)
                    user_q[gi][8*idx_q[1:0] +: 8] <= sdo_ul_data_i;
                else if (wr_user & (uidx == IW'(gi)))
                    user_q[gi] <= pwdata_i;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // tick timer
    // ----------------------------------------------------------------
    wire tick      = !idle && (tick_div_q == TICK_LAST);
    wire timed_out = !idle && (tick_cnt_q >= timeout_q);

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i || start || idle)
        begin
            tick_div_q <= 12'h000;
            tick_cnt_q <= 16'h0000;
        end
        else
        begin
            tick_div_q <= tick ? 12'h000 : tick_div_q + 12'h001;
            if (tick && tick_cnt_q != 16'hFFFF)
                tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // sequencing and outcome
    // ----------------------------------------------------------------
    wire fin_rsp = (state_q == SDC_ST_XFER) & sdo_rsp_valid_i;
    wire fin_rej = start_bad | (fin_rsp & ((sdo_rsp_code_i != `SDC_RSP_OK) | ovf_q | ul_over));
    wire fin_ok  = fin_rsp & ~fin_rej;
    wire fin_to  = timed_out & ~fin_rsp;
    wire fin_any = fin_rej | fin_ok | fin_to;
    wire res_z   = fin_ok;
    wire res_n   = fin_rej;
    wire res_p   = fin_to;
    wire acc_now = start_bad ? action_q[`SDC_ACC_BIT] : acc_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SDC_ST_IDLE:
                if (start)
                    state_d = SDC_ST_REQ;
            SDC_ST_REQ:
                if (fin_to)
                    state_d = SDC_ST_IDLE;
                else if (sdo_req_ready_i)
                    state_d = SDC_ST_XFER;
            SDC_ST_XFER:
                if (fin_any)
                    state_d = SDC_ST_IDLE;
            default:
                state_d = SDC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            state_q <= SDC_ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            zero_q <= 1'b0;
            neg_q  <= 1'b0;
            pos_q  <= 1'b0;
        end
        else if (fin_any && acc_now)
        begin
            zero_q <= zero_q & res_z;
            neg_q  <= neg_q | res_n;
            pos_q  <= pos_q | res_p;
        end
        else if (fin_any)
        begin
            zero_q <= res_z;
            neg_q  <= res_n;
            pos_q  <= res_p;
        end
    end

    // request fields latched at start
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            acc_q        <= 1'b0;
            upload_q     <= 1'b0;
            client_obj_q <= `SDC_OBJ_CLIENT1;
            size_q       <= 16'h0000;
        end
        else if (start)
        begin
            acc_q        <= action_q[`SDC_ACC_BIT];
            upload_q     <= is_up;
            client_obj_q <= (client_q == `SDC_CLIENT2) ? `SDC_OBJ_CLIENT2 : `SDC_OBJ_CLIENT1;
            size_q       <= lim;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            idx_q      <= 16'h0000;
            ovf_q      <= 1'b0;
            dl_valid_q <= 1'b0;
            dl_byte_q  <= 8'h00;
        end
        else
        begin
            idx_q      <= idx_d;
            ovf_q      <= start ? 1'b0 : (ovf_q | ul_over);
            dl_valid_q <= (state_d == SDC_ST_XFER) && !upload_q && (idx_d < size_q);
            dl_byte_q  <= byte_of(src_word, idx_d[1:0]);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sdo_req_valid_o  = (state_q == SDC_ST_REQ);
    assign sdo_upload_o     = upload_q;
    assign sdo_client_obj_o = client_obj_q;
    assign sdo_index_o      = index_q;
    assign sdo_subidx_o     = subidx_q;
    assign sdo_size_o       = size_q;
    assign sdo_dl_valid_o   = dl_valid_q;
    assign sdo_dl_data_o    = dl_byte_q;
    assign sdo_ul_ready_o   = (state_q == SDC_ST_XFER) & upload_q;
    assign busy_o           = !idle;
    assign isw_zero_o       = zero_q;
    assign isw_neg_o        = neg_q;
    assign isw_pos_o        = pos_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_timeout_flags;
        (fin_to && !acc_now) |=> (isw_pos_o && !isw_zero_o && !isw_neg_o && !busy_o);
    endproperty
    a_timeout_flags: assert property (p_timeout_flags) else $error("timeout flags wrong");

    property p_reject_flags;
        (fin_rej && !acc_now) |=> (isw_neg_o && !isw_zero_o && !isw_pos_o && !busy_o);
    endproperty
    a_reject_flags: assert property (p_reject_flags) else $error("reject flags wrong");

    property p_success_flags;
        (fin_ok && !acc_now) |=> (isw_zero_o && !isw_neg_o && !isw_pos_o);
    endproperty
    a_success_flags: assert property (p_success_flags) else $error("success flags wrong");

    property p_accumulate;
        (fin_any && acc_now) |=> (isw_neg_o >= $past(isw_neg_o)) && (isw_pos_o >= $past(isw_pos_o));
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("accumulated flag lost");

    sequence s_started;
        start ##1 sdo_req_valid_o;
    endsequence
    property p_start_request;
        start |-> s_started ##0 (sdo_upload_o == $past(is_up)) ##0 (sdo_index_o == $past(index_q));
    endproperty
    a_start_request: assert property (p_start_request) else $error("request not issued");

    property p_req_hold;
        (sdo_req_valid_o && !sdo_req_ready_i && !timed_out) |=> sdo_req_valid_o && $stable(sdo_index_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");

    property p_tick_step;
        (tick && tick_cnt_q < 16'h00FF) |=> (tick_cnt_q == $past(tick_cnt_q) + 16'h0001);
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("tick count not advanced");

    property p_client_obj;
        sdo_req_valid_o |-> (sdo_client_obj_o == `SDC_OBJ_CLIENT1) || (sdo_client_obj_o == `SDC_OBJ_CLIENT2);
    endproperty
    a_client_obj: assert property (p_client_obj) else $error("bad client object");

    property p_dl_cap;
        sdo_dl_valid_o |-> (idx_q < sdo_size_o) && (!is_const || idx_q < `SDC_CONST_MAX);
    endproperty
    a_dl_cap: assert property (p_dl_cap) else $error("download byte beyond limit");

    property p_ul_cap;
        ul_take |=> (idx_q <= sdo_size_o);
    endproperty
    a_ul_cap: assert property (p_ul_cap) else $error("upload beyond count");

    property p_single_cmd;
        (wr_cmd && busy_o) |=> $stable(sdo_index_o) && $stable(sdo_upload_o);
    endproperty
    a_single_cmd: assert property (p_single_cmd) else $error("command replaced while busy");

endmodule // sdc_remote_dictionary_access

`default_nettype wire

// ---- logic/sdc_consts.svh ----
// constants for the remote dictionary access block
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SDC_OFF_CMD      8'h00
`define SDC_OFF_ACTION   8'h04
`define SDC_OFF_DATA     8'h08
`define SDC_OFF_INDEX    8'h0C
`define SDC_OFF_SUBIDX   8'h10
`define SDC_OFF_COUNT    8'h14
`define SDC_OFF_TIMEOUT  8'h18
`define SDC_OFF_CLIENT   8'h1C
`define SDC_OFF_STATUS   8'h20
`define SDC_OFF_USER     8'h40

// ----------------------------------------------------------------
// command words and fields
// ----------------------------------------------------------------
`define SDC_OPCODE       32'h0000_0050
`define SDC_ACC_BIT      2
`define SDC_LONG_BIT     15
`define SDC_CONST_MAX    16'h0004
`define SDC_CLIENT1      16'h0001
`define SDC_CLIENT2      16'h0002
`define SDC_OBJ_CLIENT1  16'h1280
`define SDC_OBJ_CLIENT2  16'h1281
`define SDC_RSP_OK       2'h0
`define SDC_ST_BUSY      0
`define SDC_ST_ZERO      1
`define SDC_ST_NEG       2
`define SDC_ST_POS       3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDC_TICK_NS      120000
`define SDC_CLK_NS       50
`define SDC_TICK_CYC     ((`SDC_TICK_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)

`endif

// ---- logic/sdc_pkg.sv ----
// types for the remote dictionary access block
`default_nettype none
package sdc_pkg;
    typedef enum logic [1:0]
    {
        SDC_ST_IDLE = 2'b00,
        SDC_ST_REQ  = 2'b01,
        SDC_ST_XFER = 2'b10
    } sdc_state_type;

    typedef enum logic [1:0]
    {
        SDC_ACT_UPLOAD   = 2'b00,
        SDC_ACT_DL_REG   = 2'b01,
        SDC_ACT_DL_CONST = 2'b10
    } sdc_action_type;
endpackage
`default_nettype wire

// ---- tb/sdc_server_model.sv ----
// sdo server model standing on the far side of the remote dictionary block
`timescale 1ns/1ps
`default_nettype none
module sdc_server_model (
    // clock and reset
    input  wire logic        clock_i, reset_n_i,
    // request
    input  wire logic        req_valid_i, upload_i,
    input  wire logic [15:0] obj_i, index_i, size_i,
    input  wire logic [7:0]  subidx_i,
    output logic             req_ready_o,
    // byte streams and completion
    input  wire logic        dl_valid_i, ul_ready_i,
    input  wire logic [7:0]  dl_data_i,
    output logic             dl_ready_o, ul_valid_o, rsp_valid_o,
    output logic      [7:0]  ul_data_o,
    output logic      [1:0]  rsp_code_o,
    // scenario control: 0 ok, 1 refuse, 2 silent
    input  wire logic [1:0]  mode_i,
    input  wire logic [7:0]  ul_len_i,
    output logic      [31:0] got_o,
    output logic      [55:0] tag_o
);
    logic       xfer_q;
    logic [7:0] n_q;
    wire  [7:0] n_d     = n_q + 8'h01;
    wire        ul_last = (n_d == ul_len_i);
    wire        dl_last = (n_d == size_i[7:0]);

    always_ff @(posedge clock_i)
    begin
        rsp_valid_o <= 1'b0;
        if (!reset_n_i)
        begin
            {xfer_q, n_q, req_ready_o, dl_ready_o, ul_valid_o} <= '0;
            {ul_data_o, rsp_code_o, got_o, tag_o} <= '0;
        end
        else if (!xfer_q && req_valid_i && req_ready_o)
        begin
            // one request served at a time
            req_ready_o <= 1'b0;
            tag_o       <= {size_i, obj_i, index_i, subidx_i};
            got_o       <= '0;
            n_q         <= 8'h00;
            rsp_valid_o <= (mode_i == 2'h1);
            rsp_code_o  <= mode_i;
            xfer_q      <= (mode_i == 2'h0);
            ul_valid_o  <= upload_i && mode_i == 2'h0;
            ul_data_o   <= 8'h10;
            dl_ready_o  <= !upload_i && mode_i == 2'h0;
        end
        else if (!xfer_q)
            req_ready_o <= req_valid_i && mode_i != 2'h2;
        else if (ul_valid_o && ul_ready_i)
        begin
            n_q         <= n_d;
            ul_data_o   <= ul_last ? ~ul_data_o : ul_data_o + 8'h01;
            ul_valid_o  <= !ul_last;
            rsp_valid_o <= ul_last;
            xfer_q      <= !ul_last;
        end
        else if (dl_valid_i && dl_ready_o)
        begin
            got_o[8*n_q[1:0] +: 8] <= dl_data_i;
            n_q         <= n_d;
            dl_ready_o  <= !dl_last;
            rsp_valid_o <= dl_last;
            xfer_q      <= !dl_last;
        end
    end
endmodule // sdc_server_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the remote dictionary access block
`include "sdc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr, err_q;
    logic req_valid, req_ready, upload, dl_valid, dl_ready, ul_valid, ul_ready, rsp_valid, busy;
    logic [7:0] paddr, ul_len, dl_data, ul_data, subidx;
    logic [31:0] pwdata, prdata, q, got;
    logic [15:0] obj, index, size;
    logic [1:0] rsp_code, mode;
    logic zf, nf, pf;
    logic [55:0] tag;
    int errors, checked, cyc, wait_n;

    sdc_remote_dictionary_access dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sdo_req_valid_o(req_valid), .sdo_req_ready_i(req_ready),
        .sdo_upload_o(upload), .sdo_client_obj_o(obj), .sdo_index_o(index), .sdo_subidx_o(subidx),
        .sdo_size_o(size), .sdo_dl_valid_o(dl_valid), .sdo_dl_data_o(dl_data), .sdo_dl_ready_i(dl_ready),
        .sdo_ul_valid_i(ul_valid), .sdo_ul_data_i(ul_data), .sdo_ul_ready_o(ul_ready),
        .sdo_rsp_valid_i(rsp_valid), .sdo_rsp_code_i(rsp_code), .busy_o(busy), .isw_zero_o(zf),
        .isw_neg_o(nf), .isw_pos_o(pf));
    sdc_server_model srv (.clock_i(clock_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid),
        .upload_i(upload), .obj_i(obj), .index_i(index), .size_i(size), .subidx_i(subidx),
        .req_ready_o(req_ready), .dl_valid_i(dl_valid), .ul_ready_i(ul_ready), .dl_data_i(dl_data),
        .dl_ready_o(dl_ready), .ul_valid_o(ul_valid), .rsp_valid_o(rsp_valid), .ul_data_o(ul_data),
        .rsp_code_o(rsp_code), .mode_i(mode), .ul_len_i(ul_len), .got_o(got), .tag_o(tag));

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // apb master, compare and closing
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clock_i);
        end
        while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // parameters, start word, bounded wait, status compare
    task automatic run(input logic [31:0] act, dat, cnt, tmo, cli, input logic [1:0] m, input logic [3:0] st);
        mode <= m;
        apb(1'b1, `SDC_OFF_ACTION, act);
        apb(1'b1, `SDC_OFF_DATA, dat);
        apb(1'b1, `SDC_OFF_INDEX, 32'h0000_2101);
        apb(1'b1, `SDC_OFF_SUBIDX, 32'h0000_0003);
        apb(1'b1, `SDC_OFF_COUNT, cnt);
        apb(1'b1, `SDC_OFF_TIMEOUT, tmo);
        apb(1'b1, `SDC_OFF_CLIENT, cli);
        apb(1'b1, `SDC_OFF_CMD, `SDC_OPCODE);
        apb(1'b1, `SDC_OFF_CMD, `SDC_OPCODE);
        wait_n = 0;
        while (busy !== 1'b0)
        begin
            @(negedge clock_i);
            wait_n++;
        end
        @(posedge clock_i);
        apb(1'b0, `SDC_OFF_STATUS, 32'h0000_0000);
        chk("status", {28'h0, st}, q);
        chk("flags", {29'h0, st[3:1]}, {29'h0, pf, nf, zf});
    endtask

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            finish_test();
        end
    end

    initial
    begin
        {psel, penable, pwrite, reset_n_i, paddr, pwdata, mode} = '0;
        ul_len = 8'h06;
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        apb(1'b0, `SDC_OFF_STATUS, 32'h0000_0000);
        chk("status_rst", 32'h0000_0000, q);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {31'h0, err_q});
        apb(1'b1, 8'h48, 32'h4433_2211);
        run(1, 2, 4, 40, 1, 0, 4'h2);
        chk("dl_reg", 32'h4433_2211, got);
        chk("client1", 32'h0000_1280, {16'h0, tag[39:24]});
        chk("entry", 32'h0021_0103, {8'h0, tag[23:0]});
        apb(1'b1, 8'h58, 32'hFFFF_FFFF);
        run(0, 5, 6, 40, 1, 0, 4'h2);
        apb(1'b0, 8'h54, 32'h0000_0000);
        chk("ul_lo", 32'h1312_1110, q);
        apb(1'b0, 8'h58, 32'h0000_0000);
        chk("ul_hi", 32'hFFFF_1514, q);
        run(2, 32'hA5A5_0F0F, 8, 40, 2, 0, 4'h2);
        chk("dl_const", 32'hA5A5_0F0F, got);
        chk("size_cap", 32'h0000_0004, {16'h0, tag[55:40]});
        chk("client2", 32'h0000_1281, {16'h0, tag[39:24]});
        run(5, 2, 4, 40, 1, 1, 4'h4);
        run(4, 9, 4, 1, 1, 2, 4'hC);
        chk("tick_wait", 32'h0000_0001, {31'h0, wait_n > 2300 && wait_n < 5000});
        run(0, 8, 4, 40, 1, 0, 4'h4);
        run(0, 7, 32'h0000_8004, 40, 1, 0, 4'h2);
        apb(1'b0, 8'h5C, 32'h0000_0000);
        chk("ul_str", 32'h1312_1110, q);
        run(1, 2, 4, 40, 3, 0, 4'h4);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
